// >>> src/pmusec_pkg.sv
package pmusec_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 25_000_000;
    localparam int unsigned T_POR_US         = 1000;
    localparam int unsigned T_TRIG_MS        = 100;
    localparam int unsigned T_EVT_MS         = 2;
    localparam int unsigned T_CHG_MS         = 500;
    localparam int unsigned T_HOLD_MS        = 1500;
    localparam int unsigned T_FAULT_MS       = 10;
    localparam int unsigned T_RSTIN_MS       = 33;
    localparam int unsigned T_SHDN_US        = 450;
    localparam int unsigned CYC_PER_US       = CLK_HZ / 1_000_000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1_000;
    localparam int unsigned POR_CYC          = T_POR_US * CYC_PER_US;
    localparam int unsigned TRIG_CYC         = T_TRIG_MS * CYC_PER_MS;
    localparam int unsigned EVT_CYC          = T_EVT_MS * CYC_PER_MS;
    localparam int unsigned CHG_CYC          = T_CHG_MS * CYC_PER_MS;
    localparam int unsigned HOLD_CYC         = T_HOLD_MS * CYC_PER_MS;
    localparam int unsigned FAULT_CYC        = T_FAULT_MS * CYC_PER_MS;
    localparam int unsigned RSTIN_CYC        = T_RSTIN_MS * CYC_PER_MS;
    localparam int unsigned SHDN_CYC         = T_SHDN_US * CYC_PER_US;
    localparam int unsigned SLOT_CYC_DEF     = 1000;
    localparam int unsigned RST_DLY_CYC_DEF  = 250000;

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    localparam int unsigned N_BLK            = 20;
    localparam int unsigned N_SLOT           = 8;
    localparam int unsigned CNT_W            = 26;
    localparam int unsigned N_PIN_EN         = 4;
    localparam int unsigned N_REG_EN         = 24;

    // ------------------------------------------------------------
    // Enable source codes
    // ------------------------------------------------------------
    localparam logic [3:0] SRC_OFF           = 4'h0;
    localparam logic [3:0] SRC_WORK          = 4'h1;
    localparam logic [3:0] SRC_REG_BASE      = 4'h2;
    localparam logic [3:0] SRC_PIN_BASE      = 4'h8;
    localparam logic [3:0] SRC_ON            = 4'hf;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] SRC_RESET         = 4'h1;
    localparam logic [2:0] SLOT_RESET        = 3'h0;

    typedef enum {
        S_POR, S_STANDBY, S_QUAL, S_SLOTS, S_WAIT_HOLD, S_IDLE, S_SLEEP,
        S_SHDN, S_SYSRST
    } pmusec_state_e;

    typedef enum logic [1:0] {
        TRG_NONE, TRG_KEY, TRG_OTHER
    } pmusec_trig_e;

    typedef struct packed {
        logic thermal_limit_high;
        logic supply_low_lockout;
        logic regulator_fault;
    } pmusec_fault_s;

    typedef struct packed {
        logic power_key_in;
        logic accessory_power_in;
        logic charger_ok;
        logic momentary_supply_loss;
        logic rtc_alarm;
    } pmusec_trig_s;

endpackage : pmusec_pkg

// >>> src/pmusec_en_sel.sv
`timescale 1ns/100ps
`default_nettype none

module pmusec_en_sel #(
    parameter int unsigned N_BLK = pmusec_pkg::N_BLK
) (
    // Mode
    input  wire logic                  i_working,
    input  wire logic                  i_sleep,
    // Sources
    input  wire logic [pmusec_pkg::N_REG_EN-1:0] i_reg_en,
    input  wire logic [pmusec_pkg::N_PIN_EN-1:0] i_pin_en,
    input  wire logic [N_BLK*4-1:0]    i_src_code,
    input  wire logic [N_BLK-1:0]      i_sleep_permit,
    input  wire logic [N_BLK-1:0]      i_seq_on,
    // Result
    output logic      [N_BLK-1:0]      o_block_en
);

    function automatic logic pick(input logic [3:0] code, input logic working,
                                  input logic [pmusec_pkg::N_REG_EN-1:0] regs,
                                  input logic [pmusec_pkg::N_PIN_EN-1:0] pins);
        logic r;
        r = 1'b0;
        if (code == pmusec_pkg::SRC_WORK) begin
            r = working;
        end else if (code == pmusec_pkg::SRC_ON) begin
            r = 1'b1;
        end else if (code >= pmusec_pkg::SRC_PIN_BASE) begin
            r = pins[code[1:0]];
        end else if (code >= pmusec_pkg::SRC_REG_BASE) begin
            r = &regs[(code - pmusec_pkg::SRC_REG_BASE) * 4 +: 2];
        end
        return r;
    endfunction : pick

    always_comb begin
        for (int b = 0; b < N_BLK; b++) begin
            o_block_en[b] = i_seq_on[b]
                          & pick(i_src_code[b*4 +: 4], i_working | i_sleep, i_reg_en, i_pin_en)
                          & (~i_sleep | i_sleep_permit[b]);
        end
    end

endmodule : pmusec_en_sel

`default_nettype wire

// >>> src/pmusec_ctrl.sv
// Summary of operation
// - Power-on reset holds about one millisecond.
// - Standby keeps all blocks disabled.
// - Key or accessory 100 ms, or charger.
// - Supply-loss or alarm waits 2 ms.
// - Charger start waits 500 ms.
// - Regulators turn on in programmed slots.
// - Release host reset once regulators on.
// - No hold in 1.5 s: shutdown, not key.
// - Hold high after release enters idle.
// - Faults or hold low 10 ms: shutdown.
// - Sleep request low from idle enters sleep.
// - Shutdown: reset low, slots off, standby.
// - Reset pin low 33 ms: system reset.
// - Always-on rail kept during system reset.
// - Option bits make reset act as shutdown.
// - Shutdown steps slots down, one per slot time.
// - Each block has four-bit source code.
// - Register or pin sources, shared freely.
// - Blocks off in sleep unless permitted.
// - Code 0001 working, 0010 register bits.
`timescale 1ns/100ps
`default_nettype none

module pmusec_ctrl #(
    parameter int unsigned N_BLK       = pmusec_pkg::N_BLK,
    parameter int unsigned POR_CYC     = pmusec_pkg::POR_CYC,
    parameter int unsigned TRIG_CYC    = pmusec_pkg::TRIG_CYC,
    parameter int unsigned EVT_CYC     = pmusec_pkg::EVT_CYC,
    parameter int unsigned CHG_CYC     = pmusec_pkg::CHG_CYC,
    parameter int unsigned HOLD_CYC    = pmusec_pkg::HOLD_CYC,
    parameter int unsigned FAULT_CYC   = pmusec_pkg::FAULT_CYC,
    parameter int unsigned RSTIN_CYC   = pmusec_pkg::RSTIN_CYC,
    parameter int unsigned SHDN_CYC    = pmusec_pkg::SHDN_CYC,
    parameter int unsigned SLOT_CYC    = pmusec_pkg::SLOT_CYC_DEF,
    parameter int unsigned RST_DLY_CYC = pmusec_pkg::RST_DLY_CYC_DEF
) (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_resetn,
    // Pins
    input  wire pmusec_pkg::pmusec_trig_s  i_trig,
    input  wire pmusec_pkg::pmusec_fault_s i_fault,
    input  wire logic                  i_host_hold_in,
    input  wire logic                  i_sleep_req_n,
    input  wire logic                  i_ext_reset_in_n,
    input  wire logic [pmusec_pkg::N_PIN_EN-1:0] i_mf_pin_en,
    // Configuration
    input  wire logic [pmusec_pkg::N_REG_EN-1:0] i_reg_en,
    input  wire logic [N_BLK*4-1:0]    i_src_code,
    input  wire logic [N_BLK-1:0]      i_sleep_permit,
    input  wire logic [N_BLK*3-1:0]    i_slot,
    input  wire logic                  i_reset_pin_shutdown_opt,
    input  wire logic                  i_reset_pin_restart_opt,
    // Outputs
    output logic                       o_host_reset_out_n,
    output logic [N_BLK-1:0]           o_block_en,
    output logic                       o_always_on_en,
    output logic                       o_regs_default,
    output logic                       o_user_regs_clear,
    output logic [3:0]                 o_mode
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int unsigned NS = 11 + pmusec_pkg::N_PIN_EN;
    logic [NS-1:0] sy1_r;
    logic [NS-1:0] sy2_r;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sy1_r <= '0;
            sy2_r <= '0;
        end else begin
            sy1_r <= {i_trig, i_fault, i_host_hold_in, i_sleep_req_n,
                      ~i_ext_reset_in_n, i_mf_pin_en};
            sy2_r <= sy1_r;
        end
    end

    pmusec_pkg::pmusec_trig_s  trg;
    pmusec_pkg::pmusec_fault_s flt;
    logic hold;
    logic sleep_n;
    logic ext_rst;
    logic [pmusec_pkg::N_PIN_EN-1:0] pins;

    assign {trg, flt, hold, sleep_n, ext_rst, pins} = sy2_r;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pmusec_pkg::pmusec_state_e  st;
        pmusec_pkg::pmusec_trig_e   cause;
        logic [pmusec_pkg::CNT_W-1:0] t;
        logic [pmusec_pkg::CNT_W-1:0] hold_t;
        logic [pmusec_pkg::CNT_W-1:0] qk;
        logic [pmusec_pkg::CNT_W-1:0] qa;
        logic [pmusec_pkg::CNT_W-1:0] qc;
        logic [pmusec_pkg::CNT_W-1:0] qe;
        logic [pmusec_pkg::CNT_W-1:0] qh;
        logic [pmusec_pkg::CNT_W-1:0] qf;
        logic [pmusec_pkg::CNT_W-1:0] qr;
        logic [2:0] slot;
        logic       evt_seen;
        logic       rst_n;
        logic       rst_as_shdn;
        logic       restart;
        logic       regs_def;
        logic       user_clr;
    } pmusec_ctrl_s;

    pmusec_ctrl_s s_r;
    pmusec_ctrl_s s_nxt;

    function automatic logic [pmusec_pkg::CNT_W-1:0] qual(
        input logic in, input logic [pmusec_pkg::CNT_W-1:0] c);
        if (!in) begin
            return '0;
        end
        return (c == '1) ? c : c + 1'b1;
    endfunction : qual

    function automatic logic reached(input logic [pmusec_pkg::CNT_W-1:0] c,
                                     input int unsigned lim);
        return c >= pmusec_pkg::CNT_W'(lim);
    endfunction : reached

    logic fault_now;
    logic work;

    always_comb begin
        s_nxt          = s_r;
        s_nxt.t        = (s_r.t == '1) ? s_r.t : s_r.t + 1'b1;
        s_nxt.regs_def = 1'b0;
        s_nxt.user_clr = 1'b0;
        s_nxt.qk = qual(trg.power_key_in, s_r.qk);
        s_nxt.qa = qual(trg.accessory_power_in, s_r.qa);
        s_nxt.qc = qual(trg.charger_ok, s_r.qc);
        s_nxt.qh = qual(~hold, s_r.qh);
        s_nxt.qf = qual(flt.regulator_fault, s_r.qf);
        s_nxt.qr = qual(ext_rst, s_r.qr);
        s_nxt.qe = s_r.evt_seen ? ((s_r.qe == '1) ? s_r.qe : s_r.qe + 1'b1) : '0;
        if ((trg.momentary_supply_loss | trg.rtc_alarm) && s_r.st == pmusec_pkg::S_STANDBY) begin
            s_nxt.evt_seen = 1'b1;
        end
        fault_now = flt.thermal_limit_high | flt.supply_low_lockout
                  | reached(s_r.qh, FAULT_CYC) | reached(s_r.qf, FAULT_CYC);
        unique case (s_r.st)
            pmusec_pkg::S_POR: begin
                s_nxt.regs_def = 1'b1;
                if (reached(s_r.t, POR_CYC)) begin
                    s_nxt.st = pmusec_pkg::S_STANDBY;
                end
            end
            pmusec_pkg::S_STANDBY: begin
                s_nxt.rst_n = 1'b0;
                if (reached(s_r.qk, TRIG_CYC) || s_r.restart) begin
                    s_nxt.cause   = s_r.restart ? pmusec_pkg::TRG_OTHER
                                                : pmusec_pkg::TRG_KEY;
                    s_nxt.restart = 1'b0;
                    s_nxt.st      = pmusec_pkg::S_SLOTS;
                    s_nxt.t       = '0;
                    s_nxt.hold_t  = '0;
                    s_nxt.slot    = pmusec_pkg::SLOT_RESET;
                end else if (reached(s_r.qa, TRIG_CYC)) begin
                    s_nxt.cause = pmusec_pkg::TRG_OTHER;
                    s_nxt.st    = pmusec_pkg::S_SLOTS;
                    s_nxt.t     = '0;
                    s_nxt.hold_t = '0;
                    s_nxt.slot  = pmusec_pkg::SLOT_RESET;
                end else if (s_r.qc != '0 || s_r.evt_seen) begin
                    s_nxt.cause = pmusec_pkg::TRG_OTHER;
                    s_nxt.st    = pmusec_pkg::S_QUAL;
                end
            end
            pmusec_pkg::S_QUAL: begin
                if (reached(s_r.qc, CHG_CYC) || reached(s_r.qe, EVT_CYC)) begin
                    s_nxt.st       = pmusec_pkg::S_SLOTS;
                    s_nxt.t        = '0;
                    s_nxt.hold_t   = '0;
                    s_nxt.slot     = pmusec_pkg::SLOT_RESET;
                    s_nxt.evt_seen = 1'b0;
                end else if (s_r.qc == '0 && !s_r.evt_seen) begin
                    s_nxt.st = pmusec_pkg::S_STANDBY;
                end
            end
            pmusec_pkg::S_SLOTS: begin
                if (reached(s_r.t, SLOT_CYC)) begin
                    s_nxt.t = '0;
                    if (s_r.slot == 3'(pmusec_pkg::N_SLOT - 1)) begin
                        s_nxt.st    = pmusec_pkg::S_WAIT_HOLD;
                        s_nxt.rst_n = 1'b1;
                    end else begin
                        s_nxt.slot = s_r.slot + 3'h1;
                    end
                end
            end
            pmusec_pkg::S_WAIT_HOLD: begin
                if (hold) begin
                    s_nxt.st = pmusec_pkg::S_IDLE;
                end else if (s_r.cause != pmusec_pkg::TRG_KEY
                             && reached(s_r.hold_t, HOLD_CYC)) begin
                    s_nxt.st = pmusec_pkg::S_SHDN;
                    s_nxt.t  = '0;
                end
            end
            pmusec_pkg::S_IDLE, pmusec_pkg::S_SLEEP: begin
                if (fault_now) begin
                    s_nxt.st = pmusec_pkg::S_SHDN;
                    s_nxt.t  = '0;
                end else if (reached(s_r.qr, RSTIN_CYC)) begin
                    s_nxt.t = '0;
                    s_nxt.qr = '0;
                    if (i_reset_pin_shutdown_opt) begin
                        s_nxt.st      = pmusec_pkg::S_SHDN;
                        s_nxt.restart = i_reset_pin_restart_opt;
                    end else begin
                        s_nxt.st       = pmusec_pkg::S_SYSRST;
                        s_nxt.hold_t   = '0;
                        s_nxt.user_clr = 1'b1;
                    end
                end else if (s_r.st == pmusec_pkg::S_IDLE && !sleep_n) begin
                    s_nxt.st = pmusec_pkg::S_SLEEP;
                end else if (s_r.st == pmusec_pkg::S_SLEEP && sleep_n) begin
                    s_nxt.st = pmusec_pkg::S_IDLE;
                end
            end
            pmusec_pkg::S_SHDN: begin
                s_nxt.rst_n = 1'b0;
                if (reached(s_r.t, SLOT_CYC)) begin
                    s_nxt.t = '0;
                    if (s_r.slot == pmusec_pkg::SLOT_RESET) begin
                        s_nxt.st       = pmusec_pkg::S_STANDBY;
                        s_nxt.regs_def = 1'b1;
                        s_nxt.cause    = pmusec_pkg::TRG_NONE;
                    end else begin
                        s_nxt.slot = s_r.slot - 3'h1;
                    end
                end
            end
            pmusec_pkg::S_SYSRST: begin
                s_nxt.rst_n = 1'b0;
                if (reached(s_r.t, RST_DLY_CYC)) begin
                    s_nxt.rst_n = 1'b1;
                    if (hold) begin
                        s_nxt.st = pmusec_pkg::S_IDLE;
                    end else if (reached(s_r.hold_t, HOLD_CYC)) begin
                        s_nxt.st = pmusec_pkg::S_SHDN;
                        s_nxt.t  = '0;
                    end
                end
            end
        endcase
        s_nxt.hold_t = (s_nxt.hold_t == '1) ? s_nxt.hold_t : s_nxt.hold_t + 1'b1;
        if (s_r.st == pmusec_pkg::S_SHDN && s_nxt.st == pmusec_pkg::S_STANDBY) begin
            s_nxt.qk = '0;
            s_nxt.qa = '0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            s_r <= '{st: pmusec_pkg::S_POR, cause: pmusec_pkg::TRG_NONE,
                     slot: pmusec_pkg::SLOT_RESET, regs_def: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Enables
    // ------------------------------------------------------------
    logic [N_BLK-1:0] seq_on;

    always_comb begin
        for (int b = 0; b < N_BLK; b++) begin
            unique case (s_r.st)
                pmusec_pkg::S_SLOTS, pmusec_pkg::S_SHDN:
                    seq_on[b] = i_slot[b*3 +: 3] <= s_r.slot;
                pmusec_pkg::S_WAIT_HOLD, pmusec_pkg::S_IDLE,
                pmusec_pkg::S_SLEEP, pmusec_pkg::S_SYSRST:
                    seq_on[b] = 1'b1;
                default:
                    seq_on[b] = 1'b0;
            endcase
        end
    end

    assign work = (s_r.st == pmusec_pkg::S_IDLE) || (s_r.st == pmusec_pkg::S_SLOTS)
               || (s_r.st == pmusec_pkg::S_WAIT_HOLD) || (s_r.st == pmusec_pkg::S_SYSRST)
               || (s_r.st == pmusec_pkg::S_SHDN);

    pmusec_en_sel #(
        .N_BLK          (N_BLK)
    ) u_sel (
        .i_working      (work),
        .i_sleep        (s_r.st == pmusec_pkg::S_SLEEP),
        .i_reg_en       (i_reg_en),
        .i_pin_en       (pins),
        .i_src_code     (i_src_code),
        .i_sleep_permit (i_sleep_permit),
        .i_seq_on       (seq_on),
        .o_block_en     (o_block_en)
    );

    assign o_host_reset_out_n = s_r.rst_n;
    assign o_always_on_en     = s_r.st != pmusec_pkg::S_POR;
    assign o_regs_default     = s_r.regs_def;
    assign o_user_regs_clear  = s_r.user_clr;
    assign o_mode             = 4'(s_r.st);

endmodule : pmusec_ctrl

`default_nettype wire

// >>> sim/pmusec_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none

module pmusec_ctrl_sva #(
    parameter int unsigned N_BLK = pmusec_pkg::N_BLK
) (
    // Clock, reset and pins
    input wire logic             i_clk_sys,
    input wire logic             i_resetn,
    input wire logic             i_host_hold_in,
    input wire logic             i_sleep_req_n,
    input wire logic             i_ext_reset_in_n,
    input wire logic [N_BLK-1:0] i_sleep_permit,
    // Watched outputs
    input wire logic             o_host_reset_out_n,
    input wire logic [N_BLK-1:0] o_block_en,
    input wire logic             o_always_on_en,
    input wire logic             o_regs_default,
    input wire logic [3:0]       o_mode
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    AST_POR_HOLD: assert property (
        $rose(i_resetn) |-> (o_mode == 4'h0 && o_regs_default)[*8])
        else $error("power-on reset left too early");
    AST_STBY_OFF: assert property (
        o_mode == 4'h1 |-> o_block_en == '0 && !o_host_reset_out_n)
        else $error("standby with a block or host running");
    AST_IDLE_ENTRY: assert property (
        $rose(o_mode == 4'h5) |-> $past(i_host_hold_in) && o_host_reset_out_n)
        else $error("idle entered without hold or released reset");
    AST_SLEEP_GO: assert property (
        o_mode == 4'h5 && !i_sleep_req_n && i_host_hold_in && i_ext_reset_in_n
        |-> ##[1:4] o_mode == 4'h6)
        else $error("sleep request ignored");
    AST_SLEEP_PERMIT: assert property (
        o_mode == 4'h6 |-> (o_block_en & ~i_sleep_permit) == '0)
        else $error("unpermitted block on in sleep");
    AST_SHDN_LOW: assert property (
        o_mode == 4'h7 |=> !o_host_reset_out_n)
        else $error("host reset released in shutdown");
    AST_SHDN_DEF: assert property (
        (o_mode == 4'h7 ##1 o_mode == 4'h1)
        |-> (o_regs_default || $past(o_regs_default)) or ##1 o_regs_default)
        else $error("no default load after shutdown");
    AST_SYSRST_QUAL: assert property (
        $rose(o_mode == 4'h8) |-> ($past(i_ext_reset_in_n, 8) == 1'b0) ##1 !o_host_reset_out_n)
        else $error("system reset without qualified pin or low host reset");
    AST_SYSRST_AON: assert property (
        o_mode == 4'h8 |-> o_always_on_en)
        else $error("always-on rail dropped in system reset");
endmodule : pmusec_ctrl_sva

bind pmusec_ctrl pmusec_ctrl_sva #(.N_BLK(N_BLK)) i_pmusec_ctrl_sva (
    .i_clk_sys, .i_resetn, .i_host_hold_in, .i_sleep_req_n, .i_ext_reset_in_n,
    .i_sleep_permit, .o_host_reset_out_n, .o_block_en, .o_always_on_en,
    .o_regs_default, .o_mode
);

`default_nettype wire

// >>> sim/pmusec_host.sv
`timescale 1ns/100ps
`default_nettype none

module pmusec_host (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    // Device side
    input  wire logic       i_host_reset_out_n,
    output logic            o_host_hold_in,
    // Bench control
    input  wire logic       i_answer,
    input  wire logic       i_drop,
    input  wire logic [7:0] i_delay
);
    logic [7:0] wait_r;

    // Hold is kept through a device reset, so only the bench ever drops it.
    // hold raise, keep
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_host_hold_in <= 1'b0;
            wait_r         <= 8'h00;
        end else if (i_drop) begin
            o_host_hold_in <= 1'b0;
            wait_r         <= 8'h00;
        end else if (!i_host_reset_out_n) begin
            wait_r <= 8'h00;
        end else if (i_answer && wait_r < i_delay) begin
            wait_r <= wait_r + 8'h01;
        end else if (i_answer) begin
            o_host_hold_in <= 1'b1;
        end
    end
endmodule : pmusec_host

`default_nettype wire

// >>> sim/pmusec_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none

module pmusec_ctrl_bench;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    localparam int unsigned NB = pmusec_pkg::N_BLK;
    logic                      i_clk_sys = 1'b0;
    logic                      i_resetn = 1'b0;
    pmusec_pkg::pmusec_trig_s  i_trig = '0;
    pmusec_pkg::pmusec_fault_s i_fault = '0;
    logic                      i_host_hold_in;
    logic                      i_sleep_req_n = 1'b1;
    logic                      i_ext_reset_in_n = 1'b1;
    logic [3:0]                i_mf_pin_en = 4'h0;
    logic [23:0]               i_reg_en = 24'h0;
    logic [NB*4-1:0]           i_src_code = '0;
    logic [NB-1:0]             i_sleep_permit = '0;
    logic [NB*3-1:0]           i_slot = '0;
    logic                      i_reset_pin_shutdown_opt = 1'b0;
    logic                      i_reset_pin_restart_opt = 1'b0;
    logic                      o_host_reset_out_n, o_always_on_en, o_regs_default;
    logic                      o_user_regs_clear;
    logic [NB-1:0]             o_block_en;
    logic [3:0]                o_mode;
    logic                      answer = 1'b1, drop = 1'b0;
    logic [7:0]                delay = 8'h04;
    logic [3:0]                exp_q[$];
    int                        n_fail = 0, checks_done = 0, seed = 32'hbc44;

    always #20 i_clk_sys = ~i_clk_sys;

    pmusec_ctrl #(.POR_CYC(20), .TRIG_CYC(10), .EVT_CYC(5), .CHG_CYC(30), .HOLD_CYC(400),
        .FAULT_CYC(8), .RSTIN_CYC(12), .SLOT_CYC(4), .RST_DLY_CYC(20)) i_pmusec_ctrl (
        .i_clk_sys, .i_resetn, .i_trig, .i_fault, .i_host_hold_in, .i_sleep_req_n,
        .i_ext_reset_in_n, .i_mf_pin_en, .i_reg_en, .i_src_code, .i_sleep_permit, .i_slot,
        .i_reset_pin_shutdown_opt, .i_reset_pin_restart_opt, .o_host_reset_out_n,
        .o_block_en, .o_always_on_en, .o_regs_default, .o_user_regs_clear, .o_mode);
    pmusec_host i_pmusec_host (.i_clk_sys, .i_resetn, .i_host_reset_out_n(o_host_reset_out_n),
        .o_host_hold_in(i_host_hold_in), .i_answer(answer), .i_drop(drop), .i_delay(delay));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic give_verdict;
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic wait_mode(input logic [3:0] m, input int lim);
        for (int k = 0; k < lim && o_mode !== m; k++) @(negedge i_clk_sys);
        if (o_mode !== m) begin
            check(32'(o_mode), 32'(m));
            give_verdict();
        end
    endtask : wait_mode

    task automatic start_up(input logic [4:0] trg);
        if (trg < 5'h08) exp_q.push_back(4'h2);
        exp_q = {exp_q, 4'h3, 4'h4, 4'h5};
        i_trig = trg;
        wait_mode(4'h5, 300);
        i_trig = '0;
    endtask : start_up

    initial begin : watch
        logic [3:0] last;
        last = 4'h0;
        forever begin
            @(posedge i_clk_sys);
            #1;
            if (o_mode !== last) begin
                check(32'(o_mode), 32'(exp_q.size() > 0 ? exp_q.pop_front() : 4'hf));
                last = o_mode;
            end
        end
    end

    initial begin : drive
        for (int i = 0; i < NB; i++) begin
            i_src_code[i*4 +: 4] = 4'(($random(seed) & 32'h7fffffff) % 15);
            i_slot[i*3 +: 3] = 3'($random(seed));
            i_sleep_permit[i] = 1'($random(seed));
        end
        i_src_code[11:0] = 12'h821;
        i_sleep_permit[1:0] = 2'b10;
        i_reg_en = 24'($random(seed)) | 24'h000003;
        i_mf_pin_en = 4'($random(seed));
        repeat (8) @(negedge i_clk_sys);
        exp_q.push_back(4'h1);
        i_resetn = 1'b1;
        wait_mode(4'h1, 60);
        check(32'(o_block_en), 32'h0);
        i_trig.power_key_in = 1'b1;
        repeat (6) @(negedge i_clk_sys);
        i_trig.power_key_in = 1'b0;
        repeat (30) @(negedge i_clk_sys);
        check(32'(o_mode), 32'h1);
        start_up(5'h10);
        repeat (4) @(negedge i_clk_sys);
        check(32'(o_block_en[2:0]), 32'({i_mf_pin_en[0], 2'b11}));
        i_reg_en[0] = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        check(32'(o_block_en[1]), 32'h0);
        i_reg_en[0] = 1'b1;
        exp_q.push_back(4'h6);
        i_sleep_req_n = 1'b0;
        wait_mode(4'h6, 20);
        repeat (2) @(negedge i_clk_sys);
        check(32'(o_block_en[1:0]), 32'h2);
        exp_q.push_back(4'h5);
        i_sleep_req_n = 1'b1;
        wait_mode(4'h5, 20);
        exp_q = {exp_q, 4'h8, 4'h5};
        i_ext_reset_in_n = 1'b0;
        wait_mode(4'h8, 40);
        repeat (2) @(negedge i_clk_sys);
        check(32'(o_host_reset_out_n), 32'h0);
        i_ext_reset_in_n = 1'b1;
        wait_mode(4'h5, 200);
        i_reset_pin_shutdown_opt = 1'b1;
        for (int i = 0; i < 2; i++) begin
            if (i == 1) start_up(5'h10);
            i_reset_pin_restart_opt = 1'(i);
            exp_q = {exp_q, 4'h7, 4'h1};
            if (i == 1) exp_q = {exp_q, 4'h3, 4'h4, 4'h5};
            i_ext_reset_in_n = 1'b0;
            wait_mode(4'h7, 40);
            i_ext_reset_in_n = 1'b1;
            wait_mode(i == 1 ? 4'h5 : 4'h1, 400);
        end
        i_reset_pin_shutdown_opt = 1'b0;
        i_reset_pin_restart_opt = 1'b0;
        for (int i = 0; i < 4; i++) begin
            {i_slot, i_mf_pin_en} = {2{$random(seed)}};
            delay = 8'($random(seed)) & 8'h3f;
            if (o_mode !== 4'h5) start_up(5'h08 >> i);
            exp_q = {exp_q, 4'h7, 4'h1};
            i_fault = pmusec_pkg::pmusec_fault_s'(3'(4 >> i));
            drop = (i == 3);
            wait_mode(4'h1, 300);
            i_fault = '0;
            drop = 1'b1;
            @(negedge i_clk_sys);
            drop = 1'b0;
        end
        answer = 1'b0;
        exp_q = {exp_q, 4'h3, 4'h4};
        i_trig.power_key_in = 1'b1;
        wait_mode(4'h4, 300);
        repeat (500) @(negedge i_clk_sys);
        check(32'(o_mode), 32'h4);
        exp_q = {exp_q, 4'h5, 4'h7, 4'h1, 4'h3, 4'h4, 4'h7, 4'h1};
        answer = 1'b1;
        wait_mode(4'h5, 100);
        i_trig.power_key_in = 1'b0;
        drop = 1'b1;
        wait_mode(4'h1, 300);
        drop = 1'b0;
        answer = 1'b0;
        i_trig.accessory_power_in = 1'b1;
        wait_mode(4'h7, 600);
        i_trig.accessory_power_in = 1'b0;
        wait_mode(4'h1, 200);
        repeat (5) @(negedge i_clk_sys);
        check(32'(exp_q.size()), 32'h0);
        give_verdict();
    end
endmodule : pmusec_ctrl_bench

`default_nettype wire
